//--- core/scdiv_top.sv
// system clock source select and divider with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "scdiv_cfg.svh"
module scdiv_top
#(
   parameter logic [3:0] MIN_DIV = 4'h3
)
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   input wire logic main_osc_tick_in,
   input wire logic internal_osc_tick_in,
   input wire logic slow_osc_tick_in,
   input wire logic pll_tick_in,
   output logic sys_tick_out,
   output logic pll_power_down_out,
   output logic [3:0] crystal_freq_code_out,
   output var scdiv_pkg::scdiv_osc_t osc_source_select_out,
   output var scdiv_pkg::scdiv_div_t eff_divisor_out
);
   import scdiv_pkg::*;

   // ==========================================
   // elaboration checks
   if (MIN_DIV == 4'h0)
   begin : g_bad_min
      $error("MIN_DIV must be nonzero");
   end

   // ==========================================
   // bus address phase capture
   logic wr_q;
   logic rd_q;
   logic [11:0] addr_q;
   logic req;
   assign req = hsel_in && hready_in && htrans_in[1];

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 12'h000;
      end
      else
      begin
         wr_q <= req && hwrite_in && (hsize_in == 3'h2);
         rd_q <= req && !hwrite_in;
         addr_q <= haddr_in[11:0];
      end
   end

   // zero wait states, always okay
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   // ==========================================
   // software registers
   logic [3:0] div_q;
   logic diven_q;
   logic pdn_q;
   logic byp_q;
   logic [3:0] crys_q;
   logic [1:0] osc_q;
   logic ovr_q;
   logic [3:0] alt_q;
   logic wr_run;
   logic wr_sec;
   assign wr_run = wr_q && (addr_q == `SCD_RUN_CFG_OFS);
   assign wr_sec = wr_q && (addr_q == `SCD_SECOND_CFG_OFS);

   // run configuration register fields
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         div_q <= `SCD_DIV_RST; // [R1]
         diven_q <= `SCD_DIVEN_RST; // [R4]
         pdn_q <= `SCD_PDN_RST; // [R7]
         byp_q <= `SCD_BYP_RST; // [R8]
         crys_q <= `SCD_CRYS_RST; // [R10]
         osc_q <= `SCD_OSC_RST; // [R13]
      end
      else if (wr_run)
      begin
         div_q <= hwdata_in[`SCD_DIV_HI:`SCD_DIV_LO]; // [R1]
         diven_q <= hwdata_in[`SCD_DIVEN_BIT]; // [R4]
         pdn_q <= hwdata_in[`SCD_PDN_BIT]; // [R7]
         byp_q <= hwdata_in[`SCD_BYP_BIT]; // [R8]
         crys_q <= hwdata_in[`SCD_CRYS_HI:`SCD_CRYS_LO]; // [R10]
         osc_q <= hwdata_in[`SCD_OSC_HI:`SCD_OSC_LO]; // [R13]
      end
   end

   // second configuration register fields
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ovr_q <= `SCD_OVR_RST;
         alt_q <= `SCD_ALT_RST;
      end
      else if (wr_sec)
      begin
         ovr_q <= hwdata_in[`SCD_OVR_BIT];
         alt_q <= hwdata_in[`SCD_ALT_HI:`SCD_ALT_LO];
      end
   end

   // ==========================================
   // active settings, taken only at period boundaries
   logic act_byp_q;
   logic act_diven_q;
   logic [1:0] act_osc_q;
   logic [3:0] act_div_q;
   logic [3:0] cnt_q;
   logic [1:0] pre_q;
   logic sel_tick;
   logic osc_tick;
   logic src_tick;
   logic div_used;
   logic [3:0] prog_div;
   logic [3:0] eff_div;
   logic boundary;

   // programmed divisor, override from second register
   assign prog_div = ovr_q ? alt_q : div_q; // [R6]

   // oscillator source mux with internal divide by four
   always_comb
   begin
      case (scdiv_osc_t'(act_osc_q))
         SCD_MAIN_OSC: osc_tick = main_osc_tick_in;
         SCD_INTERNAL_OSC: osc_tick = internal_osc_tick_in;
         SCD_INTERNAL_OSC_DIV4: osc_tick = internal_osc_tick_in && (pre_q == 2'h3);
         default: osc_tick = slow_osc_tick_in;
      endcase
   end

   // bypass picks oscillator, else PLL
   assign src_tick = act_byp_q ? osc_tick : pll_tick_in; // [R8] [R9]
   // PLL always runs through the divider
   assign div_used = act_diven_q || !act_byp_q; // [R4] [R5]
   // clamp only while PLL feeds the system
   assign eff_div = (!act_byp_q && (act_div_q < MIN_DIV)) ? MIN_DIV : act_div_q; // [R2] [R3]
   assign boundary = src_tick && (!div_used || (cnt_q >= eff_div));
   assign sel_tick = boundary;

   // internal oscillator prescaler
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         pre_q <= 2'h0;
      else if (internal_osc_tick_in)
         pre_q <= pre_q + 2'h1;
   end

   // period counter, restarts on every output tick
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         cnt_q <= 4'h0;
      else if (boundary)
         cnt_q <= 4'h0; // [R14]
      else if (src_tick)
         cnt_q <= cnt_q + 4'h1;
   end

   // new source and divisor load only after a full period
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         act_byp_q <= `SCD_BYP_RST;
         act_diven_q <= `SCD_DIVEN_RST;
         act_osc_q <= `SCD_OSC_RST;
         act_div_q <= `SCD_DIV_RST;
      end
      else if (boundary)
      begin
         act_byp_q <= byp_q; // [R14]
         act_diven_q <= diven_q;
         act_osc_q <= osc_q;
         act_div_q <= prog_div;
      end
   end

   // ==========================================
   // outputs to the clock tree
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         sys_tick_out <= 1'b0;
         eff_divisor_out <= `SCD_DIV_RST;
      end
      else
      begin
         sys_tick_out <= sel_tick;
         eff_divisor_out <= eff_div;
      end
   end

   assign pll_power_down_out = pdn_q; // [R7]
   assign crystal_freq_code_out = crys_q; // [R10]
   assign osc_source_select_out = scdiv_osc_t'(osc_q);

   // ==========================================
   // read data, decoded from the data-phase address
   always_comb
   begin
      hrdata_out = 32'h0000_0000;
      if (!rd_q)
         hrdata_out = 32'h0000_0000;
      else if (addr_q == `SCD_RUN_CFG_OFS)
      begin
         hrdata_out[`SCD_DIV_HI:`SCD_DIV_LO] = div_q;
         hrdata_out[`SCD_DIVEN_BIT] = diven_q;
         hrdata_out[`SCD_PDN_BIT] = pdn_q;
         hrdata_out[`SCD_RSV1_BIT] = 1'b1; // [R12]
         hrdata_out[`SCD_BYP_BIT] = byp_q;
         hrdata_out[`SCD_CRYS_HI:`SCD_CRYS_LO] = crys_q;
         hrdata_out[`SCD_OSC_HI:`SCD_OSC_LO] = osc_q;
      end
      else if (addr_q == `SCD_SECOND_CFG_OFS)
      begin
         hrdata_out[`SCD_OVR_BIT] = ovr_q;
         hrdata_out[`SCD_ALT_HI:`SCD_ALT_LO] = alt_q;
      end
      else if (addr_q == `SCD_STATUS_OFS)
      begin
         hrdata_out[3:0] = eff_div;
         hrdata_out[5:4] = act_osc_q;
         hrdata_out[6] = act_byp_q;
         hrdata_out[7] = div_used;
      end
   end

   // ==========================================
   // assertions
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   property p_pdn_follows_write;
      (req && hwrite_in && haddr_in[11:0] == `SCD_RUN_CFG_OFS && hsize_in == 3'h2)
         ##1 1'b1 |=> pll_power_down_out == $past(hwdata_in[`SCD_PDN_BIT]);
   endproperty
   a_pdn_follows_write: assert property (p_pdn_follows_write) else $error("pdn mismatch"); // [R7]

   property p_clamp;
      (!act_byp_q && act_div_q < MIN_DIV) |-> eff_div == MIN_DIV;
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp with PLL"); // [R2]

   property p_no_clamp;
      act_byp_q |-> eff_div == act_div_q;
   endproperty
   a_no_clamp: assert property (p_no_clamp) else $error("bypass divisor altered"); // [R3]

   property p_pll_divided;
      !act_byp_q |-> div_used;
   endproperty
   a_pll_divided: assert property (p_pll_divided) else $error("PLL skips divider"); // [R5]

   property p_diven;
      act_byp_q |-> div_used == act_diven_q;
   endproperty
   a_diven: assert property (p_diven) else $error("divider enable ignored"); // [R4]

   property p_full_period;
      !boundary |=> $stable(act_div_q) && $stable(act_byp_q) && $stable(act_osc_q)
         && $stable(act_diven_q);
   endproperty
   a_full_period: assert property (p_full_period) else $error("settings moved mid period"); // [R14]

   property p_tick_source;
      sys_tick_out |-> $past(src_tick);
   endproperty
   a_tick_source: assert property (p_tick_source) else $error("tick off source"); // [R14]

   property p_bypass_src;
      act_byp_q |-> src_tick == osc_tick;
   endproperty
   a_bypass_src: assert property (p_bypass_src) else $error("bypass source"); // [R8]

   property p_pll_src;
      !act_byp_q |-> src_tick == pll_tick_in;
   endproperty
   a_pll_src: assert property (p_pll_src) else $error("PLL source"); // [R9]

   property p_override;
      (boundary && ovr_q) |=> act_div_q == $past(alt_q);
   endproperty
   a_override: assert property (p_override) else $error("override divisor"); // [R6]

   property p_reserved;
      (rd_q && addr_q == `SCD_RUN_CFG_OFS) |->
         hrdata_out[12] && hrdata_out[21:14] == 8'h00 && !hrdata_out[10];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits"); // [R12]
endmodule
`default_nettype wire

//--- core/scdiv_cfg.svh
// constants for the system clock divider and select block
//
// Functional notes
// [R1] four-bit divisor, bits 26:23, reset 0xF
// [R2] PLL in use: clamp divisor to minimum
// [R3] PLL unused: divisor applied as written
// [R4] divider enable bit 22, reset 0
// [R5] PLL source always goes through divider
// [R6] override bit selects alternate divisor field
// [R7] bit 13 drives PLL power down, reset 1
// [R8] bypass bit 11 set: oscillator clocks system
// [R9] bypass clear: divided PLL clocks system
// [R10] crystal code bits 9:6, reset 0xB
// [R11] software avoids crystal codes 0-3 with PLL
// [R12] bit 12 reads one, 21:14, 10 zero
// [R13] two-bit oscillator source select, reset 1
// [R14] source switches without short clock pulses
`ifndef SCDIV_CFG_SVH
`define SCDIV_CFG_SVH
// ==========================================
// register offsets
`define SCD_RUN_CFG_OFS 12'h060
`define SCD_SECOND_CFG_OFS 12'h070
`define SCD_STATUS_OFS 12'h074
// ==========================================
// run_clock_config fields
`define SCD_DIV_HI 26
`define SCD_DIV_LO 23
`define SCD_DIVEN_BIT 22
`define SCD_PDN_BIT 13
`define SCD_RSV1_BIT 12
`define SCD_BYP_BIT 11
`define SCD_CRYS_HI 9
`define SCD_CRYS_LO 6
`define SCD_OSC_HI 5
`define SCD_OSC_LO 4
`define SCD_DIV_RST 4'hF
`define SCD_CRYS_RST 4'hB
`define SCD_OSC_RST 2'h1
`define SCD_DIVEN_RST 1'b0
`define SCD_PDN_RST 1'b1
`define SCD_BYP_RST 1'b1
// ==========================================
// second_clock_config fields
`define SCD_OVR_BIT 31
`define SCD_ALT_HI 26
`define SCD_ALT_LO 23
`define SCD_ALT_RST 4'hF
`define SCD_OVR_RST 1'b0
`endif

//--- core/scdiv_pkg.sv
// types for the system clock divider and select block
package scdiv_pkg;
   // oscillator source choices
   typedef enum logic [1:0] {
      SCD_MAIN_OSC,
      SCD_INTERNAL_OSC,
      SCD_INTERNAL_OSC_DIV4,
      SCD_SLOW_OSC
   } scdiv_osc_t;
   typedef logic [3:0] scdiv_div_t;
endpackage

//--- test/tb_top.sv
// self-checking bench for the system clock divider and select block
`timescale 1ns/10ps
`default_nettype none
`include "scdiv_cfg.svh"
module tb_top;
   import scdiv_pkg::*;
   // ==========================================
   // stimulus and observed signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [2:0] tcnt = 3'h0;
   logic hready;
   logic hresp;
   logic [31:0] hrdata;
   logic sys_tick;
   logic pdn;
   logic [3:0] crys;
   scdiv_osc_t src_sel;
   scdiv_div_t eff;
   logic [31:0] rdat;
   int n_fail = 0;
   int compares = 0;
   // ==========================================
   // device under test, single slave so hready is its own
   scdiv_top #(.MIN_DIV(4'h3)) DUT
   (
      .clk_in(clk),
      .resetn_in(resetn),
      .hsel_in(hsel),
      .haddr_in(haddr),
      .htrans_in(htrans),
      .hwrite_in(hwrite),
      .hsize_in(hsize),
      .hwdata_in(hwdata),
      .hready_in(hready),
      .hreadyout_out(hready),
      .hresp_out(hresp),
      .hrdata_out(hrdata),
      .main_osc_tick_in(tcnt[0]),
      .internal_osc_tick_in(tcnt[1:0] == 2'h0),
      .slow_osc_tick_in(tcnt == 3'h0),
      .pll_tick_in(tcnt[0]),
      .sys_tick_out(sys_tick),
      .pll_power_down_out(pdn),
      .crystal_freq_code_out(crys),
      .osc_source_select_out(src_sel),
      .eff_divisor_out(eff)
   );
   // ==========================================
   // clock and source ticks: main and pll every 2nd cycle, internal 4th, slow 8th
   always #5 clk = ~clk;
   always @(posedge clk) tcnt <= tcnt + 3'h1;
   // ==========================================
   // shared helpers
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      compares++;
      if (got !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, e);
      end
   endtask
   // bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int i;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (hready !== 1'b1 && i < 20);
      if (hready !== 1'b1)
      begin
         n_fail++;
         $display("unexpected at %0t: no hready", $time);
         give_verdict();
      end
   endtask
   // one single transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [2:0] s);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= s;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rdat = hrdata;
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000, 3'h2);
      chk(rdat, e);
   endtask
   // poll the effective divisor under a bound
   task automatic wait_eff(input logic [3:0] e);
      for (int i = 0; i < 200 && eff !== e; i++) @(posedge clk);
      chk(eff, e);
      if (eff !== e)
         give_verdict();
   endtask
   // cycles between system ticks, third interval after a change
   task automatic per(input logic [7:0] e);
      logic [7:0] n;
      n = 8'h00;
      repeat (3)
      begin
         n = 8'h00;
         do
         begin
            @(negedge clk);
            n++;
         end
         while (sys_tick !== 1'b1 && n < 8'h80);
      end
      chk(n, e);
      @(posedge clk);
      if (n == 8'h80)
         give_verdict();
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk(pdn, 1'b1);
      chk(crys, 4'hB);
      chk(src_sel, 2'h1);
      chk(eff, 4'hF);
      rc(`SCD_RUN_CFG_OFS, 32'h0780_3AD0);
      rc(`SCD_SECOND_CFG_OFS, 32'h0780_0000);
      $display("test reset done");
   endtask
   task automatic t_osc;
      logic [7:0] pexp [4] = '{8'h02, 8'h04, 8'h10, 8'h08};
      for (int k = 0; k < 4; k++)
      begin
         xfer(1'b1, `SCD_RUN_CFG_OFS, 32'h0780_3AC0 | (k << 4), 3'h2);
         rc(`SCD_RUN_CFG_OFS, 32'h0780_3AC0 | (k << 4));
         chk(src_sel, k[1:0]);
         per(pexp[k]);
      end
      $display("test source select done");
   endtask
   task automatic t_div;
      xfer(1'b1, `SCD_RUN_CFG_OFS, 32'h00C0_2AC0, 3'h2);
      wait_eff(4'h1);
      per(8'd4);
      xfer(1'b1, `SCD_RUN_CFG_OFS, 32'h0080_2AC0, 3'h2);
      per(8'd2);
      xfer(1'b1, `SCD_RUN_CFG_OFS, 32'h0080_02C0, 3'h2);
      wait_eff(4'h3);
      per(8'd8);
      chk(pdn, 1'b0);
      $display("test divider done");
   endtask
   task automatic t_ovr;
      xfer(1'b1, `SCD_SECOND_CFG_OFS, 32'h8280_0000, 3'h2);
      rc(`SCD_SECOND_CFG_OFS, 32'h8280_0000);
      wait_eff(4'h5);
      rc(`SCD_STATUS_OFS, 32'h0000_0085);
      per(8'd12);
      xfer(1'b1, `SCD_SECOND_CFG_OFS, 32'h0000_0000, 3'h2);
      wait_eff(4'h3);
      $display("test override done");
   endtask
   task automatic t_regs;
      xfer(1'b1, `SCD_RUN_CFG_OFS, 32'hFFFF_FFFF, 3'h2);
      rc(`SCD_RUN_CFG_OFS, 32'h07C0_3BF0);
      xfer(1'b1, `SCD_RUN_CFG_OFS, 32'h0000_0000, 3'h1);
      rc(`SCD_RUN_CFG_OFS, 32'h07C0_3BF0);
      chk(crys, 4'hF);
      chk(src_sel, 2'h3);
      chk(pdn, 1'b1);
      rc(32'h0000_0100, 32'h0000_0000);
      chk(hresp, 1'b0);
      $display("test register map done");
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_osc();
      t_div();
      t_ovr();
      t_regs();
      // mid-run reset, everything back to defaults
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      give_verdict();
   end
endmodule
`default_nettype wire
